/* core/dfm_adc_ctrl.sv */
// single-shot diagnostic conversion sequencer
`timescale 1ns/1ps
module dfm_adc_ctrl #(
  parameter int CONV_CYCLES = dfm_pkg::CONV_CYCLES_DEF
) (
  input  wire logic        clock,
  input  wire logic        rst_n,
  dfm_adc_if.ctrl          cv,
  input  wire logic [11:0] raw_data,
  output logic             conv_start,
  output logic [4:0]       mux
);
  typedef enum logic [0:0] {
    DFM_IDLE = 1'b0,
    DFM_CONV = 1'b1
  } dfm_cst_t;

  dfm_cst_t    st_r, st_nxt;
  logic [15:0] cnt_r, cnt_nxt;
  logic        go_nxt;
  logic [4:0]  mux_nxt;
  logic [4:0]  ch_nxt;
  logic [11:0] dat_nxt;

  always_comb begin
    st_nxt  = st_r;
    cnt_nxt = cnt_r;
    go_nxt  = 1'b0;
    mux_nxt = mux;
    ch_nxt  = cv.res_ch;
    dat_nxt = cv.res_data;
    unique case (st_r)
      DFM_IDLE: begin
        if (cv.start) begin
          st_nxt  = DFM_CONV;
          go_nxt  = 1'b1;
          mux_nxt = cv.sel;
          cnt_nxt = 16'(CONV_CYCLES - 1);
        end
      end
      DFM_CONV: begin
        // further starts are dropped here
        if (cnt_r == 16'h0000) begin
          st_nxt  = DFM_IDLE;
          ch_nxt  = mux;
          dat_nxt = raw_data;
        end else begin
          cnt_nxt = cnt_r - 16'h0001;
        end
      end
    endcase
    if (!rst_n) begin
      st_nxt  = DFM_IDLE;
      cnt_nxt = 16'h0000;
      go_nxt  = 1'b0;
      mux_nxt = 5'h00;
      ch_nxt  = 5'h00;
      dat_nxt = 12'h000;
    end
  end

  always_ff @(posedge clock) begin
    st_r        <= st_nxt;
    cnt_r       <= cnt_nxt;
    conv_start  <= go_nxt;
    mux         <= mux_nxt;
    cv.res_ch   <= ch_nxt;
    cv.res_data <= dat_nxt;
  end

  assign cv.busy = (st_r == DFM_CONV);
endmodule

/* core/dfm_adc_if.sv */
// link between the monitor core and the conversion sequencer
`timescale 1ns/1ps
interface dfm_adc_if;
  logic        start;
  logic [4:0]  sel;
  logic        busy;
  logic [4:0]  res_ch;
  logic [11:0] res_data;
  modport ctrl (input start, sel, output busy, res_ch, res_data);
  modport core (output start, sel, input busy, res_ch, res_data);
endinterface

/* core/dfm_pkg.sv */
// shared constants of the diagnostic fault and converter monitor
package dfm_pkg;
  // register addresses
  localparam logic [4:0] ADDR_SETUP_ONE = 5'h02;
  localparam logic [4:0] ADDR_SETUP_TWO = 5'h03;
  localparam logic [4:0] ADDR_ALARM_MASK = 5'h04;
  localparam logic [4:0] ADDR_CHAN_CFG = 5'h05;
  localparam logic [4:0] ADDR_ANA_FLAGS = 5'h06;
  localparam logic [4:0] ADDR_STATUS = 5'h07;
  // reset values
  localparam logic [15:0] SETUP_ONE_RST = 16'h0000;
  localparam logic [15:0] SETUP_TWO_RST = 16'h0000;
  localparam logic [15:0] ALARM_MASK_RST = 16'h0000;
  localparam logic [15:0] CHAN_CFG_RST = 16'h0000;
  // setup one fields
  localparam int TRIP_LSB = 4;
  localparam int QUIET_BIT = 3;
  // trip codes: 00 142C, 01 127C, 10 112C, 11 97C
  localparam logic [1:0] TRIP_142C = 2'h0;
  localparam logic [1:0] TRIP_97C = 2'h3;
  // setup two comparator field
  localparam int CMP_LSB = 0;
  // channel config fields
  localparam int SEL_LSB = 0;
  localparam logic [2:0] START_HI = 3'h4;
  localparam logic [2:0] START_LO = 3'h0;
  // digital flag positions
  localparam int DF_OSC = 0;
  localparam int DF_CAL_UNREF = 1;
  localparam int DF_RESET = 2;
  localparam int DF_WDT = 3;
  localparam int DF_LATCH = 4;
  localparam int DF_INVERSE = 5;
  localparam int DF_CALCRC = 6;
  localparam int DF_INVALID = 7;
  localparam int DF_CLKCNT = 8;
  localparam int DF_SLIP = 9;
  localparam int DF_SERCRC = 10;
  localparam int DF_SLEW = 11;
  localparam int DIG_W = 12;
  // analog flag positions
  localparam int AF_EXTREF = 0;
  localparam int AF_REFERENCE_OUTPUT_NODE = 1;
  localparam int AF_REG = 2;
  localparam int AF_AVCC = 3;
  localparam int AF_TEMP = 4;
  localparam int AF_OPEN = 5;
  localparam int AF_SHORT = 6;
  localparam int ANA_W = 7;
  // alarm mask positions
  localparam int MK_OSC = 0;
  localparam int MK_WDT = 1;
  localparam int MK_LATCH = 2;
  localparam int MK_INVERSE = 3;
  localparam int MK_INVALID = 4;
  localparam int MK_SLIP = 5;
  localparam int MK_SERCRC = 6;
  localparam int MK_OPEN = 7;
  localparam int MK_SHORT = 8;
  localparam int MK_TEMP = 9;
  // status word sync pattern
  localparam logic [1:0] SYNC_PAT = 2'h2;
  // conversion latency in oscillator cycles
  localparam int CONV_CYCLES_DEF = 40;
endpackage

/* core/dfm_sync.sv */
// two-stage synchroniser bank
`timescale 1ns/1ps
module dfm_sync #(
  parameter int W = 1
) (
  input  wire logic         clock,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] s1_r;
  logic [W-1:0] s1_nxt;
  logic [W-1:0] q_nxt;

  always_comb begin
    s1_nxt = rst_n ? d : '0;
    q_nxt  = rst_n ? s1_r : '0;
  end

  always_ff @(posedge clock) begin
    s1_r <= s1_nxt;
    q    <= q_nxt;
  end
endmodule

/* core/dfm_top.sv */
// diagnostic flag latching, alarm line and converter control
// How it works
// - two-bit field in setup one picks trip level 142, 127, 112 or 97 C
// - over-temperature sets the temperature flag and pulls the alarm low
// - temperature comparison is always active, nothing disables it
// - node comparator monitoring is off after reset until setup two enables it
// - one sticky flag per monitored node, set when it leaves its window
// - reference output fault sets its own flag; dependent flags may follow
// - analog flags are sticky; writing one clears only once the cause is gone
// - alarm is active-low open-drain: released with no fault, low with one
// - alarm is driven by all listed digital faults except calibration-not-refreshed, reset and slew busy, and by all analog faults
// - ten faults are maskable; cal CRC, clock count, node comparators are not
// - calibration-not-refreshed and reset flags never reach the alarm
// - quiet-diagnostics bit keeps clock count error off the alarm
// - every readback carries the inverted present alarm pin level
// - digital, analog and watchdog summaries are reported beside alarm status
// - converter mux select is bits 4 to 0 of the channel config register
// - mux codes select the documented nodes; other codes are reserved
// - channel config write with bits 10:8 = 100, 7:5 = 000 starts one conversion
// - a finished conversion places its 12-bit result in the status word
// - summaries are plain ORs; digital one leaves out slew busy
// - status holds last result with the channel that produced it
// - while converting, busy shows and new starts are ignored
`timescale 1ns/1ps
module dfm_top #(
  parameter int CONV_CYCLES = dfm_pkg::CONV_CYCLES_DEF
) (
  input  wire logic                       clock,
  input  wire logic                       rst_n,
  input  wire logic                       reg_wr,
  input  wire logic [4:0]                 reg_addr,
  input  wire logic [15:0]                reg_wdata,
  input  wire logic [4:0]                 rd_addr,
  input  wire logic [dfm_pkg::DIG_W-1:0]  dig_flags,
  input  wire logic                       watchdog_summary_bit,
  input  wire logic                       temp_over_raw,
  input  wire logic [3:0]                 node_fault_raw,
  input  wire logic                       open_raw,
  input  wire logic                       short_raw,
  input  wire logic                       alarm_pin_in,
  input  wire logic [11:0]                adc_raw_data,
  output logic                            alarm_out,
  output logic                            alarm_oe,
  output logic [1:0]                      temp_trip_sel,
  output logic                            cmp_enable,
  output logic [4:0]                      adc_mux,
  output logic                            adc_start,
  output logic [dfm_pkg::ANA_W-1:0]       ana_flags,
  output logic [23:0]                     status_word,
  output logic [23:0]                     rd_data
);
  // mux select codes
  localparam logic [4:0] SEL_TEMP    = 5'h00;
  localparam logic [4:0] SEL_EXTREF  = 5'h03;
  localparam logic [4:0] SEL_BANDGAP = 5'h04;
  localparam logic [4:0] SEL_SENSE_P = 5'h0D;
  localparam logic [4:0] SEL_SENSE_N = 5'h0E;
  localparam logic [4:0] SEL_AVCC    = 5'h14;
  localparam logic [4:0] SEL_LOGIC   = 5'h16;
  localparam logic [4:0] SEL_REFERENCE_GROUND_NODE  = 5'h18;
  localparam logic [4:0] SEL_DIGITAL_GROUND_NODE    = 5'h1A;
  localparam logic [4:0] SEL_HV_ONE  = 5'h1B;
  localparam logic [4:0] SEL_HV_NEG  = 5'h1D;
  localparam logic [4:0] SEL_REFERENCE_OUTPUT_NODE  = 5'h1F;

  function automatic logic sel_valid(input logic [4:0] s);
    sel_valid = (s == SEL_TEMP) || (s == SEL_EXTREF) || (s == SEL_BANDGAP) ||
                (s == SEL_SENSE_P) || (s == SEL_SENSE_N) ||
                (s >= SEL_AVCC && s <= SEL_LOGIC) ||
                (s >= SEL_REFERENCE_GROUND_NODE && s <= SEL_HV_NEG) || (s == SEL_REFERENCE_OUTPUT_NODE);
  endfunction

  dfm_adc_if cv ();

  // analog inputs into the clock domain
  logic                      temp_over;
  logic [3:0]                node_fault;
  logic                      open_flt;
  logic                      short_flt;
  logic                      pin_level;

  dfm_sync #(.W(8)) u_sync (
    .clock (clock),
    .rst_n (rst_n),
    .d     ({alarm_pin_in, short_raw, open_raw, node_fault_raw, temp_over_raw}),
    .q     ({pin_level, short_flt, open_flt, node_fault, temp_over})
  );

  dfm_adc_ctrl #(.CONV_CYCLES(CONV_CYCLES)) u_adc (
    .clock      (clock),
    .rst_n      (rst_n),
    .cv         (cv.ctrl),
    .raw_data   (adc_raw_data),
    .conv_start (adc_start),
    .mux        (adc_mux)
  );

  // register write side
  logic [15:0] setup_one_r, setup_one_nxt;
  logic [15:0] setup_two_r, setup_two_nxt;
  logic [15:0] mask_r, mask_nxt;
  logic [15:0] chan_r, chan_nxt;
  logic        start_nxt;
  logic        start_r;

  always_comb begin
    setup_one_nxt = setup_one_r;
    setup_two_nxt = setup_two_r;
    mask_nxt      = mask_r;
    chan_nxt      = chan_r;
    start_nxt     = 1'b0;
    if (reg_wr) begin
      unique case (reg_addr)
        dfm_pkg::ADDR_SETUP_ONE:  setup_one_nxt = reg_wdata;
        dfm_pkg::ADDR_SETUP_TWO:  setup_two_nxt = reg_wdata;
        dfm_pkg::ADDR_ALARM_MASK: mask_nxt = reg_wdata;
        dfm_pkg::ADDR_CHAN_CFG: begin
          chan_nxt  = reg_wdata;
          start_nxt = (reg_wdata[10:8] == dfm_pkg::START_HI) &&
                      (reg_wdata[7:5] == dfm_pkg::START_LO);
        end
        default: ;
      endcase
    end
    if (!rst_n) begin
      setup_one_nxt = dfm_pkg::SETUP_ONE_RST;
      setup_two_nxt = dfm_pkg::SETUP_TWO_RST;
      mask_nxt      = dfm_pkg::ALARM_MASK_RST;
      chan_nxt      = dfm_pkg::CHAN_CFG_RST;
      start_nxt     = 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    setup_one_r <= setup_one_nxt;
    setup_two_r <= setup_two_nxt;
    mask_r      <= mask_nxt;
    chan_r      <= chan_nxt;
    start_r     <= start_nxt;
  end

  assign cv.start = start_r;
  assign cv.sel   = chan_r[dfm_pkg::SEL_LSB +: 5];

  // analog sticky flags
  logic [dfm_pkg::ANA_W-1:0] cause;
  logic [dfm_pkg::ANA_W-1:0] w1c;
  logic [dfm_pkg::ANA_W-1:0] ana_nxt;
  logic                      cmp_on;

  always_comb begin
    cmp_on = |setup_two_r[dfm_pkg::CMP_LSB +: 2];
    cause  = '0;
    cause[dfm_pkg::AF_TEMP]   = temp_over;
    cause[dfm_pkg::AF_EXTREF] = cmp_on & node_fault[0];
    cause[dfm_pkg::AF_REFERENCE_OUTPUT_NODE] = cmp_on & node_fault[1];
    cause[dfm_pkg::AF_REG]    = cmp_on & node_fault[2];
    cause[dfm_pkg::AF_AVCC]   = cmp_on & node_fault[3];
    cause[dfm_pkg::AF_OPEN]   = open_flt;
    cause[dfm_pkg::AF_SHORT]  = short_flt;
    w1c = '0;
    if (reg_wr && reg_addr == dfm_pkg::ADDR_ANA_FLAGS) begin
      w1c = reg_wdata[dfm_pkg::ANA_W-1:0];
    end
    // a live cause always wins over the clear
    ana_nxt = (ana_flags & ~w1c) | cause;
    if (!rst_n) begin
      ana_nxt = '0;
    end
  end

  always_ff @(posedge clock) begin
    ana_flags <= ana_nxt;
  end

  // alarm line
  logic [dfm_pkg::DIG_W-1:0] dig_hit;
  logic [dfm_pkg::ANA_W-1:0] ana_hit;
  logic                      fault_nxt;

  always_comb begin
    dig_hit = '0;
    dig_hit[dfm_pkg::DF_OSC]     = dig_flags[dfm_pkg::DF_OSC] &
                                   ~mask_r[dfm_pkg::MK_OSC];
    dig_hit[dfm_pkg::DF_WDT]     = dig_flags[dfm_pkg::DF_WDT] &
                                   ~mask_r[dfm_pkg::MK_WDT];
    dig_hit[dfm_pkg::DF_LATCH]   = dig_flags[dfm_pkg::DF_LATCH] &
                                   ~mask_r[dfm_pkg::MK_LATCH];
    dig_hit[dfm_pkg::DF_INVERSE] = dig_flags[dfm_pkg::DF_INVERSE] &
                                   ~mask_r[dfm_pkg::MK_INVERSE];
    dig_hit[dfm_pkg::DF_CALCRC]  = dig_flags[dfm_pkg::DF_CALCRC];
    dig_hit[dfm_pkg::DF_INVALID] = dig_flags[dfm_pkg::DF_INVALID] &
                                   ~mask_r[dfm_pkg::MK_INVALID];
    dig_hit[dfm_pkg::DF_CLKCNT]  = dig_flags[dfm_pkg::DF_CLKCNT] &
                                   ~setup_one_r[dfm_pkg::QUIET_BIT];
    dig_hit[dfm_pkg::DF_SLIP]    = dig_flags[dfm_pkg::DF_SLIP] &
                                   ~mask_r[dfm_pkg::MK_SLIP];
    dig_hit[dfm_pkg::DF_SERCRC]  = dig_flags[dfm_pkg::DF_SERCRC] &
                                   ~mask_r[dfm_pkg::MK_SERCRC];
    // calibration-unrefreshed, reset and slew bits stay zero here
    ana_hit = ana_flags;
    ana_hit[dfm_pkg::AF_OPEN]  = ana_flags[dfm_pkg::AF_OPEN] &
                                 ~mask_r[dfm_pkg::MK_OPEN];
    ana_hit[dfm_pkg::AF_SHORT] = ana_flags[dfm_pkg::AF_SHORT] &
                                 ~mask_r[dfm_pkg::MK_SHORT];
    ana_hit[dfm_pkg::AF_TEMP]  = ana_flags[dfm_pkg::AF_TEMP] &
                                 ~mask_r[dfm_pkg::MK_TEMP];
    fault_nxt = rst_n & ((|dig_hit) | (|ana_hit));
  end

  always_ff @(posedge clock) begin
    alarm_oe  <= fault_nxt;
    alarm_out <= 1'b0;
  end

  // configuration outputs
  always_ff @(posedge clock) begin
    temp_trip_sel <= setup_one_nxt[dfm_pkg::TRIP_LSB +: 2];
    cmp_enable    <= |setup_two_nxt[dfm_pkg::CMP_LSB +: 2];
  end

  // status word and readback
  localparam logic [dfm_pkg::DIG_W-1:0] DIG_W1 = 1;

  logic        dig_sum;
  logic        ana_sum;
  logic        pin_stat;
  logic [23:0] stat_nxt;
  logic [15:0] rd_word;
  logic [23:0] rd_nxt;

  always_comb begin
    dig_sum  = |(dig_flags & ~(DIG_W1 << dfm_pkg::DF_SLEW));
    ana_sum  = |ana_flags;
    pin_stat = ~pin_level;
    stat_nxt = {dfm_pkg::SYNC_PAT, pin_stat, dig_sum, ana_sum, watchdog_summary_bit,
                cv.busy, cv.res_ch, cv.res_data};
    rd_word  = 16'h0000;
    unique case (rd_addr)
      dfm_pkg::ADDR_SETUP_ONE:  rd_word = setup_one_r;
      dfm_pkg::ADDR_SETUP_TWO:  rd_word = setup_two_r;
      dfm_pkg::ADDR_ALARM_MASK: rd_word = mask_r;
      dfm_pkg::ADDR_CHAN_CFG:   rd_word = chan_r;
      dfm_pkg::ADDR_ANA_FLAGS:  rd_word = 16'(ana_flags);
      default:                  rd_word = 16'h0000;
    endcase
    rd_nxt = {dfm_pkg::SYNC_PAT, pin_stat, rd_addr, rd_word};
    if (rd_addr == dfm_pkg::ADDR_STATUS) begin
      rd_nxt = stat_nxt;
    end
    if (!rst_n) begin
      stat_nxt = 24'h000000;
      rd_nxt   = 24'h000000;
    end
  end

  always_ff @(posedge clock) begin
    status_word <= stat_nxt;
    rd_data     <= rd_nxt;
  end

  // reserved mux codes still convert; software reads the code back
  logic sel_ok_unused;
  assign sel_ok_unused = sel_valid(cv.sel);
endmodule

/* verification/dfm_alarm_wire.sv */
// open-drain alarm wire model with pull-up and a second device on it
`timescale 1ns/1ps
module dfm_alarm_wire (
  input  wire logic alarm_oe,
  input  wire logic other_oe,
  output logic      alarm_wire
);
  // any enabled driver pulls low, otherwise the pull-up wins
  assign alarm_wire = (alarm_oe || other_oe) ? 1'b0 : 1'b1;
endmodule

/* verification/dfm_top_monitor.sv */
// concurrent checks on the diagnostic monitor ports
`timescale 1ns/1ps
module dfm_top_monitor #(
  parameter int CONV_CYCLES = dfm_pkg::CONV_CYCLES_DEF
) (
  input wire logic        clock,
  input wire logic        rst_n,
  input wire logic        reg_wr,
  input wire logic [4:0]  reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic [11:0] dig_flags,
  input wire logic        temp_over_raw,
  input wire logic        alarm_pin_in,
  input wire logic [11:0] adc_raw_data,
  input wire logic        alarm_out,
  input wire logic        alarm_oe,
  input wire logic        cmp_enable,
  input wire logic [4:0]  adc_mux,
  input wire logic        adc_start,
  input wire logic [6:0]  ana_flags,
  input wire logic [23:0] status_word,
  input wire logic [23:0] rd_data
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  logic       sw;
  logic [6:0] keep;
  logic [2:0] run_r, run_nxt, since_r, since_nxt;
  logic [4:0] sel_r, sel_nxt;
  assign sw = reg_wr && reg_addr == dfm_pkg::ADDR_CHAN_CFG
    && reg_wdata[10:8] == dfm_pkg::START_HI && reg_wdata[7:5] == dfm_pkg::START_LO;
  assign keep = ana_flags & ~((reg_wr && reg_addr == dfm_pkg::ADDR_ANA_FLAGS)
    ? reg_wdata[6:0] : 7'h00);
  always_comb begin
    run_nxt = (run_r == 3'h7) ? run_r : run_r + 3'h1;
    since_nxt = sw ? 3'h0 : ((since_r == 3'h7) ? since_r : since_r + 3'h1);
    sel_nxt = sw ? reg_wdata[4:0] : sel_r;
  end
  always_ff @(posedge clock) begin
    run_r <= rst_n ? run_nxt : 3'h0;
    since_r <= rst_n ? since_nxt : 3'h0;
    sel_r <= rst_n ? sel_nxt : 5'h00;
  end
  AST_START_PULSE: assert property (adc_start |=> !adc_start)
    else $error("start pulse longer than one cycle");
  AST_START_TAKEN: assert property (sw && !status_word[17] && !adc_start && since_r > 3'h3
    |-> ##[2:3] (adc_start && adc_mux == sel_r))
    else $error("start write did not launch a conversion");
  AST_BUSY_SHOWN: assert property (adc_start |-> ##[1:2] status_word[17])
    else $error("busy not shown after start");
  AST_RESULT: assert property (adc_start |-> ##CONV_CYCLES status_word[17] ##1
    (!status_word[17] && status_word[16:12] == adc_mux
    && status_word[11:0] == adc_raw_data))
    else $error("result or latency wrong");
  AST_OD_DATA: assert property (alarm_out == 1'b0)
    else $error("open-drain data not low");
  AST_TEMP_SET: assert property (temp_over_raw [*3] |-> ##1 ana_flags[dfm_pkg::AF_TEMP])
    else $error("temperature flag not set");
  AST_STICKY: assert property (1'b1 |=> ((ana_flags & $past(keep)) == $past(keep)))
    else $error("analog flag dropped without clear");
  AST_NODE_ALARM: assert property (ana_flags[3:0] != 4'h0 [*2] |-> alarm_oe)
    else $error("node fault not on alarm");
  AST_NO_ALARM: assert property (((dig_flags & 12'h7F9) == 12'h000 && ana_flags == 7'h00)
    [*2] |-> !alarm_oe)
    else $error("alarm without mapped fault");
  AST_CMP_OFF: assert property (!cmp_enable && ana_flags[3:0] == 4'h0 ##1 !cmp_enable
    |-> ana_flags[3:0] == 4'h0)
    else $error("node flag set while monitoring off");
  AST_ALARM_MIRROR: assert property (run_r == 3'h7 |-> rd_data[21] == !$past(alarm_pin_in, 3)
    && rd_data[23:22] == dfm_pkg::SYNC_PAT)
    else $error("alarm status bit wrong");
  COV_CONV: cover property (adc_start);
  COV_ALARM: cover property ($rose(alarm_oe));
  COV_CLEAR: cover property ($fell(ana_flags[dfm_pkg::AF_TEMP]));
endmodule

/* verification/diag_fault_and_adc_monitor_test.sv */
// self-checking bench of the diagnostic monitor
`timescale 1ns/1ps
module diag_fault_and_adc_monitor_test;
  localparam int CC = 4;
  localparam logic [11:0] MAPPED = 12'h7F9;
  localparam logic [15:0] MTAB [12] = '{16'h1, 16'h0, 16'h0, 16'h2, 16'h4, 16'h8,
    16'h0, 16'h10, 16'h0, 16'h20, 16'h40, 16'h0};
  localparam logic [15:0] MKA [3] = '{16'h0200, 16'h0080, 16'h0100};
  localparam logic [4:0] CODES [15] = '{5'h00, 5'h03, 5'h04, 5'h0D, 5'h0E, 5'h14, 5'h15,
    5'h16, 5'h18, 5'h19, 5'h1A, 5'h1B, 5'h1C, 5'h1D, 5'h1F};
  logic        clock, rst_n, reg_wr, watchdog_summary_bit, other_oe, alarm_wire, prev_busy;
  logic [4:0]  reg_addr, rd_addr, sel;
  logic [15:0] reg_wdata, mk;
  logic [11:0] dig_flags, adc_raw_data;
  logic [3:0]  node_fault_raw;
  logic [2:0]  src;
  logic        alarm_out, alarm_oe, cmp_enable, adc_start;
  logic [1:0]  temp_trip_sel;
  logic [4:0]  adc_mux;
  logic [6:0]  ana_flags;
  logic [23:0] status_word, rd_data;
  logic [16:0] exp_q [$];
  int          mismatches, total_checks, n_starts, seed;
  dfm_top #(.CONV_CYCLES(CC)) dut (.clock(clock), .rst_n(rst_n), .reg_wr(reg_wr),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .rd_addr(rd_addr), .dig_flags(dig_flags),
    .watchdog_summary_bit(watchdog_summary_bit), .temp_over_raw(src[0]), .node_fault_raw(node_fault_raw),
    .open_raw(src[1]), .short_raw(src[2]), .alarm_pin_in(alarm_wire),
    .adc_raw_data(adc_raw_data), .alarm_out(alarm_out), .alarm_oe(alarm_oe),
    .temp_trip_sel(temp_trip_sel), .cmp_enable(cmp_enable), .adc_mux(adc_mux),
    .adc_start(adc_start), .ana_flags(ana_flags), .status_word(status_word),
    .rd_data(rd_data));
  dfm_alarm_wire u_wire (.alarm_oe(alarm_oe), .other_oe(other_oe), .alarm_wire(alarm_wire));
  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic wt(input int n);
    repeat (n) @(negedge clock);
  endtask
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(negedge clock);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge clock);
    reg_wr = 1'b0;
  endtask
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  // result scoreboard: a falling busy bit marks a finished conversion
  always @(negedge clock) begin
    if (prev_busy === 1'b1 && status_word[17] === 1'b0) begin
      if (exp_q.size() > 0) check(status_word[16:0], exp_q.pop_front());
      else check(1'b1, 1'b0);
    end
    prev_busy = status_word[17];
  end
  always @(posedge clock) if (adc_start === 1'b1) n_starts++;
  initial begin
    repeat (20000) @(posedge clock);
    mismatches++;
    report_and_stop();
  end
  initial begin
    {rst_n, reg_wr, watchdog_summary_bit, other_oe, prev_busy, src, node_fault_raw} = '0;
    {reg_addr, rd_addr, reg_wdata, dig_flags, adc_raw_data} = '0;
    seed = 52922;
    wt(3);
    rst_n = 1'b1;
    wr(5'h1F, 16'hFFFF);
    wr(dfm_pkg::ADDR_STATUS, 16'hFFFF);
    for (int a = 2; a < 6; a++) begin
      rd_addr = a[4:0];
      wt(3);
      check(rd_data, {2'h2, 1'b0, a[4:0], 16'h0000});
    end
    check(status_word[17:0], 18'h00000);
    $display("test reset done");
    for (int k = 0; k < 4; k++) begin
      wr(dfm_pkg::ADDR_SETUP_ONE, 16'(k << dfm_pkg::TRIP_LSB));
      wt(2);
      check(temp_trip_sel, k[1:0]);
    end
    wr(dfm_pkg::ADDR_SETUP_ONE, 16'h0000);
    $display("test trip done");
    for (int b = 0; b < 12; b++) begin
      dig_flags = 12'h001 << b;
      for (int m = 0; m < 3; m++) begin
        mk = (m == 0) ? 16'h0000 : (m == 1) ? MTAB[b] : 16'h03FF & ~MTAB[b];
        wr(dfm_pkg::ADDR_ALARM_MASK, mk);
        wt(6);
        check(alarm_oe, MAPPED[b] && !(m == 1 && MTAB[b] != 16'h0));
        check(rd_data[21], MAPPED[b] && !(m == 1 && MTAB[b] != 16'h0));
      end
      check(status_word[20], b != 11);
    end
    dig_flags = 12'h100;
    wr(dfm_pkg::ADDR_SETUP_ONE, 16'h0008);
    wt(3);
    check(alarm_oe, 1'b0);
    wr(dfm_pkg::ADDR_SETUP_ONE, 16'h0000);
    wt(3);
    check(alarm_oe, 1'b1);
    dig_flags = 12'h000;
    watchdog_summary_bit = 1'b1;
    wr(dfm_pkg::ADDR_ALARM_MASK, 16'h0000);
    wt(3);
    check(status_word[18], 1'b1);
    watchdog_summary_bit = 1'b0;
    $display("test digital done");
    for (int k = 0; k < 3; k++) begin
      src = 3'h1 << k;
      wt(5);
      check(ana_flags, 7'h10 << k);
      check(alarm_oe, 1'b1);
      check(alarm_out, 1'b0);
      check(status_word[19], 1'b1);
      wr(dfm_pkg::ADDR_ALARM_MASK, MKA[k]);
      wt(3);
      check(alarm_oe, 1'b0);
      wr(dfm_pkg::ADDR_ANA_FLAGS, 16'h007F);
      wt(3);
      check(ana_flags, 7'h10 << k);
      src = 3'h0;
      wt(5);
      check(ana_flags, 7'h10 << k);
      wr(dfm_pkg::ADDR_ANA_FLAGS, 16'h007F);
      wt(3);
      check(ana_flags, 7'h00);
      check(status_word[19], 1'b0);
      wr(dfm_pkg::ADDR_ALARM_MASK, 16'h0000);
    end
    node_fault_raw = 4'hF;
    wt(5);
    check(ana_flags, 7'h00);
    wr(dfm_pkg::ADDR_SETUP_TWO, 16'h0001);
    wt(5);
    check(cmp_enable, 1'b1);
    check(ana_flags, 7'h0F);
    wr(dfm_pkg::ADDR_ALARM_MASK, 16'h03FF);
    wt(3);
    check(alarm_oe, 1'b1);
    node_fault_raw = 4'h2;
    wt(3);
    wr(dfm_pkg::ADDR_ANA_FLAGS, 16'h007F);
    wt(3);
    check(ana_flags, 7'h02);
    node_fault_raw = 4'h0;
    wt(3);
    wr(dfm_pkg::ADDR_ANA_FLAGS, 16'h007F);
    wt(3);
    check(ana_flags, 7'h00);
    other_oe = 1'b1;
    wt(5);
    check({alarm_oe, rd_data[21]}, 2'h1);
    other_oe = 1'b0;
    $display("test analog done");
    for (int i = 0; i < 16; i++) begin
      sel = (i == 15) ? 5'($random(seed)) : CODES[i];
      adc_raw_data = 12'($random(seed));
      exp_q.push_back({sel, adc_raw_data});
      wr(dfm_pkg::ADDR_CHAN_CFG, {5'h00, dfm_pkg::START_HI, dfm_pkg::START_LO, sel});
      for (int n = 0; n < 10 && adc_start !== 1'b1; n++) @(negedge clock);
      check({adc_start, adc_mux}, {1'b1, sel});
      wr(dfm_pkg::ADDR_CHAN_CFG, {5'h00, dfm_pkg::START_HI, dfm_pkg::START_LO, ~sel});
      check({status_word[17], adc_mux}, {1'b1, sel});
      for (int n = 0; n < CC + 10 && status_word[17] !== 1'b0; n++) @(negedge clock);
      wt(2);
    end
    wr(dfm_pkg::ADDR_CHAN_CFG, 16'h0420);
    wr(dfm_pkg::ADDR_CHAN_CFG, 16'h0015);
    wt(10);
    check(n_starts, 16);
    check(exp_q.size(), 0);
    $display("test conversion done");
    report_and_stop();
  end
endmodule
bind dfm_top dfm_top_monitor #(.CONV_CYCLES(CONV_CYCLES)) u_mon (.clock(clock),
  .rst_n(rst_n), .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .dig_flags(dig_flags), .temp_over_raw(temp_over_raw), .alarm_pin_in(alarm_pin_in),
  .adc_raw_data(adc_raw_data), .alarm_out(alarm_out), .alarm_oe(alarm_oe),
  .cmp_enable(cmp_enable), .adc_mux(adc_mux), .adc_start(adc_start),
  .ana_flags(ana_flags), .status_word(status_word), .rd_data(rd_data));
